/* File: rtl/sdram_cfg_consts.svh */
// Constants for the SDRAM configuration and power-up sequencer
`ifndef SDRAM_CFG_CONSTS_SVH
`define SDRAM_CFG_CONSTS_SVH
// ----------------------------------------
// Register map
// ----------------------------------------
`define SDRAM_CONTROL_ADDR 12'h000
`define SDRAM_STATUS_ADDR 12'h004
`define SDRAM_CONTROL_RESET 32'h0000_0000
`define SDRAM_CONTROL_WMASK 32'h0000_FFBF
// ----------------------------------------
// Field positions
// ----------------------------------------
`define FLD_ENABLE 0
`define FLD_CAS_LO 1
`define FLD_PIPE 3
`define FLD_PAGE_LO 4
`define FLD_REF_LO 7
`define FLD_PC2RAS_LO 9
`define FLD_RAS2PC_LO 11
`define FLD_INIT_ORDER 14
`define FLD_EXT_MODE 15
// ----------------------------------------
// Timing counts
// ----------------------------------------
`define REF_CYC_0 12'd1100
`define REF_CYC_1 12'd1850
`define REF_CYC_2 12'd2200
`define REF_CYC_3 12'd3700
`define INIT_REFRESH_COUNT 4'd8
`define PC2RAS_BASE 3'd2
`define RAS2PC_BASE 3'd2
`define REFRESH_GAP_CYC 4'd6
`endif

/* File: rtl/sdram_cfg_init.sv */
// SDRAM controller configuration register and power-up / refresh sequencer
//
// Functional notes
// R1: Pipeline bit only for buffered parallel memories
// R2: Page field sets columns per bank
// R3: Refresh field picks reload count, max 3700
// R4: Software keeps interval within row refresh budget
// R5: Precharge-to-activate gap from field
// R6: Activate-to-precharge minimum from field
// R7: Init order one: precharge, eight refreshes, mode set
// R8: Extended mode only for low-power parts
// R9: Control register resets to zero
// R10: Writing valid configuration starts initialization
// R11: Mode set fixes full-page sequential burst
// R12: Host accesses memory only after init
// R13: Documented bit layout of control register
// R14: Software recomputes timing fields on clock change
// R15: Refresh codes select 1100/1850/2200/3700
// R16: Init order zero puts mode set first
// R17: Extended mode cycle precedes mode set
// R18: Zero register disables interface, no commands
// R19: Counter expiry: precharge, one refresh, reload
// R20: Reserved bits ignored, read as zero
`include "sdram_cfg_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module sdram_cfg_init (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Refresh timebase enable, one pulse per soc_clock period
	input wire logic soc_clock_tick,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// SDRAM command pins
	output sdram_cfg_pkg::sdram_cmd_bus_t sdram_cmd,
	output logic sdram_cke,
	// Configuration seen by the datapath
	output logic [1:0] cas_latency,
	output logic pipeline_depth_setting,
	output logic [1:0] column_bits_sel,
	output logic init_done
);
	// ----------------------------------------
	// Register file
	// ----------------------------------------
	logic [31:0] sdram_control;
	logic start_pending;
	wire logic acc = psel && penable;
	wire logic hit_ctrl = paddr == `SDRAM_CONTROL_ADDR;
	wire logic hit_stat = paddr == `SDRAM_STATUS_ADDR;
	wire logic ctrl_wr = acc && pwrite && hit_ctrl;
	wire logic [31:0] wr_val = pwdata & `SDRAM_CONTROL_WMASK; // [R20]
	wire logic valid_cfg = wr_val[`FLD_ENABLE] && (wr_val[5:4] != 2'b11); // [R10]
	sdram_cfg_pkg::seq_state_t state;
	sdram_cfg_pkg::seq_state_t next_state;
	wire logic [31:0] status_word = {27'h0, init_done, 1'b0, state};
	wire logic [31:0] next_prdata = hit_ctrl ? sdram_control : (hit_stat ? status_word : 32'h0000_0000);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sdram_control <= `SDRAM_CONTROL_RESET; // [R9]
			start_pending <= 1'b0;
		end else begin
			if (ctrl_wr) begin
				sdram_control <= wr_val; // [R13] [R20]
			end
			if (ctrl_wr && valid_cfg) begin
				start_pending <= 1'b1; // [R10]
			end else if (state == sdram_cfg_pkg::ST_PRE) begin
				start_pending <= 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !(paddr == `SDRAM_CONTROL_ADDR || paddr == `SDRAM_STATUS_ADDR);
			prdata <= (psel && !penable && !pwrite) ? next_prdata : 32'h0000_0000;
		end
	end

	// ----------------------------------------
	// Field decode
	// ----------------------------------------
	wire logic interface_enable_bit = sdram_control[`FLD_ENABLE];
	wire logic init_order_bit = sdram_control[`FLD_INIT_ORDER];
	wire logic extended_mode_enable_bit = sdram_control[`FLD_EXT_MODE];
	wire logic [1:0] ref_code = sdram_control[`FLD_REF_LO +: 2];
	wire logic [2:0] pc2ras = `PC2RAS_BASE + {1'b0, sdram_control[`FLD_PC2RAS_LO +: 2]}; // [R5]
	wire logic [3:0] ras2pc = {1'b0, `RAS2PC_BASE} + {1'b0, sdram_control[`FLD_RAS2PC_LO +: 3]}; // [R6]
	wire logic [11:0] ref_reload = (ref_code == 2'd0) ? `REF_CYC_0 :
		(ref_code == 2'd1) ? `REF_CYC_1 :
		(ref_code == 2'd2) ? `REF_CYC_2 : `REF_CYC_3; // [R3] [R15]
	// Mode word: burst length full page, sequential, latency from the field
	wire logic [12:0] mode_word = {6'h00, 1'b0, sdram_control[`FLD_CAS_LO +: 2], 1'b0, 3'b111}; // [R11]

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cas_latency <= 2'b00;
			pipeline_depth_setting <= 1'b0;
			column_bits_sel <= 2'b00;
		end else begin
			cas_latency <= sdram_control[`FLD_CAS_LO +: 2];
			pipeline_depth_setting <= sdram_control[`FLD_PIPE]; // [R1]
			column_bits_sel <= sdram_control[`FLD_PAGE_LO +: 2]; // [R2]
		end
	end

	// ----------------------------------------
	// Refresh timebase
	// ----------------------------------------
	// Counts soc_clock ticks so the interval tracks soc_clock, not pclk
	logic [11:0] ref_count;
	logic ref_due;
	logic init_phase;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ref_count <= 12'h000;
			ref_due <= 1'b0;
		end else if (state == sdram_cfg_pkg::ST_OFF || init_phase) begin
			// Runs on through periodic refreshes so expiries stay one reload apart
			ref_count <= ref_reload;
			ref_due <= 1'b0;
		end else begin
			if (soc_clock_tick) begin
				ref_count <= (ref_count == 12'h001) ? ref_reload : ref_count - 12'h001; // [R19]
			end
			// Set wins over the clear taken when ST_READY hands over to ST_PRE
			if (soc_clock_tick && ref_count == 12'h001) begin
				ref_due <= 1'b1;
			end else if (state == sdram_cfg_pkg::ST_READY && next_state == sdram_cfg_pkg::ST_PRE) begin
				ref_due <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Command sequencer
	// ----------------------------------------
	// A small gap counter spaces every command; refresh needs the longest
	logic [3:0] gap;
	logic [3:0] refs_left;
	logic row_open;
	logic [3:0] open_age;
	logic mrs_done;
	sdram_cfg_pkg::sdram_cmd_t cmd;
	sdram_cfg_pkg::sdram_cmd_t next_cmd;
	logic [1:0] next_bank;
	logic [12:0] next_addr;
	wire logic gap_ok = gap == 4'h0;
	wire logic pre_ok = !row_open || open_age >= ras2pc; // [R6]

	always_comb begin
		next_state = state;
		next_cmd = sdram_cfg_pkg::CMD_NOP;
		next_bank = 2'b00;
		next_addr = 13'h0000;
		unique case (state)
			sdram_cfg_pkg::ST_OFF: begin
				if (start_pending && interface_enable_bit) begin
					next_state = sdram_cfg_pkg::ST_PRE;
				end
			end
			sdram_cfg_pkg::ST_PRE: begin
				if (gap_ok && pre_ok) begin
					next_cmd = sdram_cfg_pkg::CMD_PRECHARGE;
					next_addr = 13'h0400;
					if (!init_phase) begin
						next_state = sdram_cfg_pkg::ST_REF; // [R19]
					end else if (init_order_bit) begin
						next_state = sdram_cfg_pkg::ST_REF; // [R7]
					end else begin
						next_state = extended_mode_enable_bit ? sdram_cfg_pkg::ST_EMRS : sdram_cfg_pkg::ST_MRS; // [R16]
					end
				end
			end
			sdram_cfg_pkg::ST_REF: begin
				if (gap_ok) begin
					next_cmd = sdram_cfg_pkg::CMD_REFRESH;
					if (refs_left == 4'h1) begin
						if (!init_phase || mrs_done) begin
							next_state = sdram_cfg_pkg::ST_WAIT;
						end else begin
							next_state = extended_mode_enable_bit ? sdram_cfg_pkg::ST_EMRS : sdram_cfg_pkg::ST_MRS;
						end
					end
				end
			end
			sdram_cfg_pkg::ST_EMRS: begin
				if (gap_ok) begin
					next_cmd = sdram_cfg_pkg::CMD_MODE_SET;
					next_bank = 2'b10; // [R17]
					next_state = sdram_cfg_pkg::ST_MRS;
				end
			end
			sdram_cfg_pkg::ST_MRS: begin
				if (gap_ok) begin
					next_cmd = sdram_cfg_pkg::CMD_MODE_SET; // [R10]
					next_addr = mode_word; // [R11]
					next_state = init_order_bit ? sdram_cfg_pkg::ST_WAIT : sdram_cfg_pkg::ST_REF; // [R16]
				end
			end
			sdram_cfg_pkg::ST_WAIT: begin
				if (gap_ok) begin
					next_state = sdram_cfg_pkg::ST_READY;
				end
			end
			sdram_cfg_pkg::ST_READY: begin
				if (ref_due) begin
					next_state = sdram_cfg_pkg::ST_PRE; // [R19]
				end
			end
			default: begin
				next_state = sdram_cfg_pkg::ST_OFF;
			end
		endcase
		if (!interface_enable_bit) begin
			next_state = sdram_cfg_pkg::ST_OFF; // [R18]
			next_cmd = sdram_cfg_pkg::CMD_NOP;
		end else if (start_pending && state != sdram_cfg_pkg::ST_OFF && state != sdram_cfg_pkg::ST_PRE) begin
			next_state = sdram_cfg_pkg::ST_OFF;
			next_cmd = sdram_cfg_pkg::CMD_NOP;
		end
	end

	wire logic [3:0] cmd_gap = (next_cmd == sdram_cfg_pkg::CMD_REFRESH) ? `REFRESH_GAP_CYC :
		(next_cmd == sdram_cfg_pkg::CMD_PRECHARGE) ? {1'b0, pc2ras} : 4'h2; // [R5]

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= sdram_cfg_pkg::ST_OFF;
			cmd <= sdram_cfg_pkg::CMD_NOP;
			gap <= 4'h0;
			refs_left <= 4'h0;
			init_phase <= 1'b0;
			mrs_done <= 1'b0;
			row_open <= 1'b0;
			open_age <= 4'h0;
		end else begin
			state <= next_state;
			cmd <= next_cmd;
			if (next_cmd != sdram_cfg_pkg::CMD_NOP) begin
				gap <= cmd_gap - 4'h1;
			end else if (!gap_ok) begin
				gap <= gap - 4'h1;
			end
			if (state == sdram_cfg_pkg::ST_OFF) begin
				init_phase <= 1'b1;
				mrs_done <= 1'b0;
				refs_left <= `INIT_REFRESH_COUNT; // [R7]
			end else if (state == sdram_cfg_pkg::ST_READY) begin
				init_phase <= 1'b0;
				refs_left <= 4'h1; // [R19]
			end else if (next_cmd == sdram_cfg_pkg::CMD_REFRESH) begin
				refs_left <= refs_left - 4'h1;
			end
			if (next_cmd == sdram_cfg_pkg::CMD_MODE_SET && next_bank == 2'b00) begin
				mrs_done <= 1'b1;
			end
			if (next_cmd == sdram_cfg_pkg::CMD_ACTIVATE) begin
				row_open <= 1'b1;
				open_age <= 4'h0;
			end else if (next_cmd == sdram_cfg_pkg::CMD_PRECHARGE) begin
				row_open <= 1'b0;
			end else if (row_open && open_age != 4'hF) begin
				open_age <= open_age + 4'h1;
			end
		end
	end

	// ----------------------------------------
	// Pin drive
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sdram_cmd <= '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, bank: 2'b00, addr: 13'h0000};
			sdram_cke <= 1'b0;
			init_done <= 1'b0;
		end else begin
			sdram_cmd.cs_n <= !interface_enable_bit; // [R18]
			{sdram_cmd.ras_n, sdram_cmd.cas_n, sdram_cmd.we_n} <= next_cmd[2:0];
			sdram_cmd.bank <= next_bank;
			sdram_cmd.addr <= next_addr;
			sdram_cke <= interface_enable_bit;
			init_done <= next_state == sdram_cfg_pkg::ST_READY; // [R12]
		end
	end
endmodule
`default_nettype wire

/* File: rtl/sdram_cfg_pkg.sv */
// Types for the SDRAM configuration and power-up sequencer
package sdram_cfg_pkg;
	typedef enum logic [3:0] {
		CMD_NOP = 4'h7,
		CMD_ACTIVATE = 4'h3,
		CMD_PRECHARGE = 4'h2,
		CMD_REFRESH = 4'h1,
		CMD_MODE_SET = 4'h0
	} sdram_cmd_t;
	typedef struct packed {
		logic cs_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
		logic [1:0] bank;
		logic [12:0] addr;
	} sdram_cmd_bus_t;
	typedef enum logic [2:0] {
		ST_OFF = 3'b000,
		ST_PRE = 3'b001,
		ST_REF = 3'b010,
		ST_EMRS = 3'b011,
		ST_MRS = 3'b100,
		ST_READY = 3'b101,
		ST_WAIT = 3'b110
	} seq_state_t;
endpackage

/* File: test/sdram_cfg_init_properties.sv */
// Port checks for the SDRAM configuration sequencer
`timescale 1ns/1ps
`default_nettype none
module sdram_cfg_init_properties (
	// Clock, reset, bus
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Memory side
	input wire sdram_cfg_pkg::sdram_cmd_bus_t sdram_cmd,
	input wire logic sdram_cke,
	input wire logic [1:0] cas_latency,
	input wire logic pipeline_depth_setting,
	input wire logic [1:0] column_bits_sel
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire logic [2:0] op = {sdram_cmd.ras_n, sdram_cmd.cas_n, sdram_cmd.we_n};
	wire logic nop = sdram_cmd.cs_n || op == 3'h7;
	wire logic pre = !sdram_cmd.cs_n && op == 3'h2;
	wire logic rfs = !sdram_cmd.cs_n && op == 3'h1;
	wire logic mrs = !sdram_cmd.cs_n && op == 3'h0 && sdram_cmd.bank == 2'h0;
	wire logic rd = psel && penable && pready && !pwrite && paddr == 12'h000;
	// -----------------------------
	// Assertions
	// -----------------------------
	a_off_silent: assert property (!sdram_cke |-> sdram_cmd.cs_n) else $error("command while disabled");
	a_mode_burst: assert property (mrs |-> sdram_cmd.addr[3:0] == 4'h7) else $error("bad burst mode");
	a_pre_gap: assert property (pre |-> sdram_cmd.addr[10] ##1 nop) else $error("bad precharge");
	a_ref_gap: assert property (rfs |=> nop [*5]) else $error("refresh too close");
	a_setup_ready: assert property (psel && !penable |=> pready) else $error("no ready");
	a_bad_addr: assert property (pready && paddr > 12'h004 |-> pslverr && (pwrite || prdata == 32'h0))
		else $error("unmapped access accepted");
	a_reg_fields: assert property (rd |-> prdata[31:16] == 16'h0 && !prdata[6] && prdata[2:1] == cas_latency
		&& prdata[3] == pipeline_depth_setting && prdata[5:4] == column_bits_sel) else $error("field copy");
	a_cke_enable: assert property (rd |-> sdram_cke == prdata[0]) else $error("cke differs");
	c_mode: cover property (mrs);
	c_refresh: cover property (pre ##2 rfs);
	c_read: cover property (rd);
endmodule
`default_nettype wire

/* File: test/sdram_model.sv */
// Behavioural memory on the far side of the command pins
`timescale 1ns/1ps
`default_nettype none
module sdram_model (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Command pins
	input wire sdram_cfg_pkg::sdram_cmd_bus_t cmd,
	input wire logic cke,
	// Decoded command
	output logic seen,
	output logic [4:0] code,
	output logic [3:0] burst
);
	// Bank is kept for mode sets and refreshes, so both mode registers stay apart
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seen <= 1'h0;
			code <= 5'h00;
			burst <= 4'h0;
		end else begin
			seen <= cke && !cmd.cs_n && {cmd.ras_n, cmd.cas_n, cmd.we_n} != 3'h7;
			code <= {cmd.ras_n | cmd.cas_n ? 2'h0 : cmd.bank, cmd.ras_n, cmd.cas_n, cmd.we_n};
			if (!cmd.cs_n && cmd.bank == 2'h0 && {cmd.ras_n, cmd.cas_n, cmd.we_n} == 3'h0) begin
				burst <= cmd.addr[3:0];
			end
		end
	end
endmodule
`default_nettype wire

/* File: test/tb.sv */
// Self-checking bench for the SDRAM configuration sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic pclk = 1'h0;
	logic presetn = 1'h0;
	logic soc_clock_tick = 1'h0;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	wire logic [31:0] prdata;
	wire logic pready, pslverr, sdram_cke, pipeline_depth_setting, init_done, seen;
	wire logic [1:0] cas_latency, column_bits_sel;
	wire logic [4:0] code;
	wire logic [3:0] burst;
	wire sdram_cfg_pkg::sdram_cmd_bus_t sdram_cmd;
	int errors = 0;
	int tests_run = 0;
	int cyc = 0;
	int tick_mode = 0;
	int n;
	int pre_t[2];
	int gap_tbl[4] = '{1100, 1850, 2200, 3700};
	logic [4:0] cmd_q[$];
	logic [31:0] rd_q[$];
	logic [31:0] cfg;
	always #10 pclk = ~pclk;
	sdram_cfg_init dut (.pclk, .presetn, .soc_clock_tick, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .sdram_cmd, .sdram_cke, .cas_latency, .pipeline_depth_setting, .column_bits_sel, .init_done);
	sdram_model mem (.pclk, .presetn, .cmd(sdram_cmd), .cke(sdram_cke), .seen, .code, .burst);
	// ---------------------------
	// Tasks
	// ---------------------------
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic close_out;
		$display("errors %0d tests_run %0d", errors, tests_run);
		if (errors == 0 && tests_run > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do begin
			@(posedge pclk);
		end while (!pready);
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	// Mode set order follows the order bit; refreshes stay eight either way
	task automatic expect_init(input logic [31:0] c);
		cmd_q.push_back(5'h02);
		if (!c[14] && c[15]) cmd_q.push_back(5'h10);
		if (!c[14]) cmd_q.push_back(5'h00);
		repeat (8) cmd_q.push_back(5'h01);
		if (c[14] && c[15]) cmd_q.push_back(5'h10);
		if (c[14]) cmd_q.push_back(5'h00);
	endtask
	task automatic settle;
		n = 0;
		while ((cmd_q.size() != 0 || !init_done) && n < 9000) begin
			@(posedge pclk);
			n++;
		end
		chk("pending", 0, cmd_q.size());
	endtask
	always @(posedge pclk) begin
		cyc++;
		soc_clock_tick <= tick_mode != 0 && cyc % tick_mode == 0;
		if (psel && penable && pready && !pwrite) chk("read", rd_q.size() ? rd_q.pop_front() : 32'hDEAD, prdata);
		if (psel && penable && pready) chk("slverr", paddr != 12'h000 && paddr != 12'h004, pslverr);
		if (seen) begin
			if (code == 5'h02) pre_t = '{pre_t[1], cyc};
			chk("command", cmd_q.size() ? cmd_q.pop_front() : 32'hFF, code);
		end
	end
	initial begin
		#1_600_000;
		errors++;
		close_out();
	end
	// ---------------------------
	// Scenarios
	// ---------------------------
	initial begin
		void'($urandom(32'h8396A649));
		repeat (16) @(posedge pclk);
		presetn <= 1'h1;
		rd_q = '{32'h0, 32'h0};
		apb(1'h0, 12'h000, 32'h0);
		apb(1'h0, 12'h008, 32'h0);
		tick_mode = 1;
		for (int c = 0; c < 4; c++) begin
			cfg = 32'h0000_5803 | (c << 7);
			expect_init(cfg);
			repeat (2) cmd_q = {cmd_q, 5'h02, 5'h01};
			apb(1'h1, 12'h000, cfg);
			settle();
			chk("interval", gap_tbl[c], pre_t[1] - pre_t[0]);
		end
		chk("burst", 4'h7, burst);
		tick_mode = 4;
		for (int k = 0; k < 2; k++) begin
			cfg = k ? ($urandom | 32'h1) & ~32'h28 : 32'h0000_8013;
			expect_init(cfg);
			apb(1'h1, 12'h000, cfg);
			settle();
			rd_q.push_back(cfg & 32'h0000_FFBF);
			apb(1'h0, 12'h000, 32'h0);
			chk("page", cfg[5:4], column_bits_sel);
			chk("cas", cfg[2:1], cas_latency);
			chk("pipe", cfg[3], pipeline_depth_setting);
			rd_q.push_back(32'h0000_0015);
			apb(1'h0, 12'h004, 32'h0);
		end
		apb(1'h1, 12'h000, 32'h0);
		repeat (50) @(posedge pclk);
		chk("cke", 0, sdram_cke);
		close_out();
	end
endmodule
bind sdram_cfg_init sdram_cfg_init_properties u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata,
	.pready, .pslverr, .sdram_cmd, .sdram_cke, .cas_latency, .pipeline_depth_setting, .column_bits_sel);
`default_nettype wire
